// ### design/ectf_framer.sv
// Cyclic telegram framer: parses output frames, builds input frames
// How it works
// - A class input selects application class 3 or 4 and gates functions.
// - In class 3 the isochronous and scaling/preset enables stay low.
// - In class 4 isochronous operation and scaling/preset are enabled.
// - In class 4 every telegram and every function is offered.
// - Both control words and both status words are 16-bit unsigned.
// - Position values one and two are sent as 32-bit unsigned values.
// - The wide position value is sent as a 64-bit unsigned value.
// - The short speed value is a 16-bit signed value.
// - The long speed value is a 32-bit signed value.
// - The selected telegram sets the input frame length and contents.
// - Telegram 81 returns 12 octets: status two, one, positions 1 and 2.
// - Telegram 84 returns status words, wide position, position 2, speed.
`timescale 1ns/1ps
`default_nettype none
`include "ectf_cfg.svh"
module ectf_framer #(
    parameter int BUF_WIDTH = 9
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      resetn,
    // Configuration
    input  wire logic                      cfg_class4,
    input  wire ectf_pkg::ectf_tgram_t     cfg_telegram,
    // Sampled encoder signals
    input  wire logic [15:0]               encoder_status_word_two,
    input  wire logic [15:0]               encoder_status_word_one,
    input  wire logic [31:0]               position_value_first,
    input  wire logic [31:0]               position_value_second,
    input  wire logic [63:0]               position_value_wide,
    input  wire logic signed [15:0]        speed_value_short,
    input  wire logic signed [31:0]        speed_value_long,
    // Input frame request and octet stream
    input  wire logic                      frame_req,
    output logic [7:0]                     tx_data,
    output logic                           tx_last,
    output logic                           tx_valid,
    input  wire logic                      tx_ready,
    // Output frame octet stream
    input  wire logic [7:0]                rx_data,
    input  wire logic                      rx_last,
    input  wire logic                      rx_valid,
    // Parsed control words and status
    output logic [15:0]                    encoder_ctrl_word_two,
    output logic [15:0]                    encoder_ctrl_word_one,
    output logic                           rx_frame_ok,
    output logic                           rx_frame_err,
    output logic                           busy,
    output logic                           iso_enable,
    output logic                           scale_preset_enable
);
    // ************************************************************
    // Input frame assembly
    // ************************************************************
    ectf_pkg::ectf_state_t      state_reg, state_next;
    logic                       class4_reg, class4_next;
    logic [`ECTF_FRAME_BITS-1:0] frame_reg, frame_next;
    logic [7:0]                 rem_reg, rem_next;
    logic                       busy_reg, busy_next;
    logic                       buf_in_ready, buf_last, start;

    function automatic logic [`ECTF_FRAME_BITS-1:0] assemble(
        input ectf_pkg::ectf_tgram_t tg);
        logic [31:0] head;
        logic [63:0] pos12;
        head  = {encoder_status_word_two, encoder_status_word_one};
        pos12 = {position_value_first, position_value_second};
        unique case (tg)
            ectf_pkg::ECTF_TG81: assemble = {head, pos12, 64'h0};
            ectf_pkg::ECTF_TG82:
                assemble = {head, pos12, speed_value_short, 48'h0};
            ectf_pkg::ECTF_TG83:
                assemble = {head, pos12, speed_value_long, 32'h0};
            ectf_pkg::ECTF_TG84: assemble = {head, position_value_wide,
                position_value_second, speed_value_long};
        endcase
    endfunction

    function automatic logic [7:0] frame_len(
        input ectf_pkg::ectf_tgram_t tg);
        unique case (tg)
            ectf_pkg::ECTF_TG81: frame_len = `ECTF_LEN_T81;
            ectf_pkg::ECTF_TG82: frame_len = `ECTF_LEN_T82;
            ectf_pkg::ECTF_TG83: frame_len = `ECTF_LEN_T83;
            ectf_pkg::ECTF_TG84: frame_len = `ECTF_LEN_T84;
        endcase
    endfunction

    assign start    = (state_reg == ectf_pkg::ECTF_ST_IDLE) & frame_req;
    assign buf_last = (rem_reg == 8'h01);

    // Signals are frozen at the request so one frame is self-consistent
    always_comb begin
        state_next  = state_reg;
        class4_next = class4_reg;
        frame_next  = frame_reg;
        rem_next    = rem_reg;
        unique case (state_reg)
            ectf_pkg::ECTF_ST_IDLE: begin
                class4_next = cfg_class4;
                if (frame_req) begin
                    frame_next = assemble(cfg_telegram);
                    rem_next   = frame_len(cfg_telegram);
                    state_next = ectf_pkg::ECTF_ST_SEND;
                end
            end
            ectf_pkg::ECTF_ST_SEND: begin
                if (buf_in_ready) begin
                    frame_next = {frame_reg[`ECTF_FRAME_BITS-9:0], 8'h00};
                    rem_next   = rem_reg - 8'h01;
                    if (buf_last) begin
                        state_next = ectf_pkg::ECTF_ST_IDLE;
                    end
                end
            end
        endcase
        busy_next = (state_next == ectf_pkg::ECTF_ST_SEND);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_reg  <= ectf_pkg::ECTF_ST_IDLE;
            class4_reg <= 1'b0;
            frame_reg  <= '0;
            rem_reg    <= 8'h00;
            busy_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            class4_reg <= class4_next;
            frame_reg  <= frame_next;
            rem_reg    <= rem_next;
            busy_reg   <= busy_next;
        end
    end

    assign busy                = busy_reg;
    // Class 3 offers no isochronous mode and no scaling or preset
    assign iso_enable          = class4_reg;
    assign scale_preset_enable = class4_reg;

    ectf_skid_buf #(
        .WIDTH (BUF_WIDTH)
    ) u_buf (
        .clk       (clk),
        .resetn    (resetn),
        .in_data   ({buf_last, frame_reg[`ECTF_FRAME_BITS-1 -: 8]}),
        .in_valid  (state_reg == ectf_pkg::ECTF_ST_SEND),
        .in_ready  (buf_in_ready),
        .out_data  ({tx_last, tx_data}),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );

    // ************************************************************
    // Output frame parsing
    // ************************************************************
    logic [2:0]  rx_cnt_reg, rx_cnt_next;
    logic [23:0] rx_shift_reg, rx_shift_next;
    logic [15:0] ctrl2_reg, ctrl2_next, ctrl1_reg, ctrl1_next;
    logic        ok_reg, ok_next, err_reg, err_next;

    // A short or long output frame leaves the old control words in place
    always_comb begin
        rx_cnt_next   = rx_cnt_reg;
        rx_shift_next = rx_shift_reg;
        ctrl2_next    = ctrl2_reg;
        ctrl1_next    = ctrl1_reg;
        ok_next       = 1'b0;
        err_next      = 1'b0;
        if (rx_valid) begin
            if (rx_last) begin
                rx_cnt_next = 3'h0;
                if (rx_cnt_reg == `ECTF_RX_LASTIDX) begin
                    ctrl2_next = rx_shift_reg[23:8];
                    ctrl1_next = {rx_shift_reg[7:0], rx_data};
                    ok_next    = 1'b1;
                end else begin
                    err_next = 1'b1;
                end
            end else begin
                rx_shift_next = {rx_shift_reg[15:0], rx_data};
                if (rx_cnt_reg != `ECTF_RX_SAT) begin
                    rx_cnt_next = rx_cnt_reg + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_cnt_reg   <= 3'h0;
            rx_shift_reg <= 24'h0;
            ctrl2_reg    <= 16'h0;
            ctrl1_reg    <= 16'h0;
            ok_reg       <= 1'b0;
            err_reg      <= 1'b0;
        end else begin
            rx_cnt_reg   <= rx_cnt_next;
            rx_shift_reg <= rx_shift_next;
            ctrl2_reg    <= ctrl2_next;
            ctrl1_reg    <= ctrl1_next;
            ok_reg       <= ok_next;
            err_reg      <= err_next;
        end
    end

    assign encoder_ctrl_word_two = ctrl2_reg;
    assign encoder_ctrl_word_one = ctrl1_reg;
    assign rx_frame_ok           = ok_reg;
    assign rx_frame_err          = err_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_class_latch : assert property (@(posedge clk) disable iff (!resetn)
        !busy_reg |=> iso_enable == $past(cfg_class4))
        else $error("class not taken while idle");
    a_class_hold : assert property (@(posedge clk) disable iff (!resetn)
        busy_reg && busy_next |=> $stable(scale_preset_enable))
        else $error("class changed inside a frame");
    a_len_t81 : assert property (@(posedge clk) disable iff (!resetn)
        start && cfg_telegram == ectf_pkg::ECTF_TG81 |=> rem_reg == 8'h0C)
        else $error("telegram 81 length wrong");
    a_len_t82 : assert property (@(posedge clk) disable iff (!resetn)
        start && cfg_telegram == ectf_pkg::ECTF_TG82
        |=> rem_reg == 8'h0E && frame_reg[63:48] == $past(speed_value_short))
        else $error("telegram 82 frame wrong");
    a_len_t83 : assert property (@(posedge clk) disable iff (!resetn)
        start && cfg_telegram == ectf_pkg::ECTF_TG83
        |=> rem_reg == 8'h10 && frame_reg[63:32] == $past(speed_value_long))
        else $error("telegram 83 frame wrong");
    a_wide_pos : assert property (@(posedge clk) disable iff (!resetn)
        start && cfg_telegram == ectf_pkg::ECTF_TG84 |=> rem_reg == 8'h14
        && frame_reg[127:64] == $past(position_value_wide))
        else $error("telegram 84 frame wrong");
    a_first_octet : assert property (@(posedge clk) disable iff (!resetn)
        start |=> frame_reg[159:152] == $past(encoder_status_word_two[15:8]))
        else $error("status word two not sent high octet first");
    a_last_octet : assert property (@(posedge clk) disable iff (!resetn)
        busy_reg && buf_in_ready && buf_last
        |=> !busy_reg ##1 (busy_reg == $past(frame_req)))
        else $error("frame did not end after its last octet");
    a_rx_words : assert property (@(posedge clk) disable iff (!resetn)
        rx_valid && rx_last && rx_cnt_reg == 3'h3 |=> rx_frame_ok
        && encoder_ctrl_word_one[7:0] == $past(rx_data)
        && encoder_ctrl_word_two == $past(rx_shift_reg[23:8]))
        else $error("control words misplaced");
    a_rx_error : assert property (@(posedge clk) disable iff (!resetn)
        rx_valid && rx_last && rx_cnt_reg != 3'h3
        |=> rx_frame_err && !rx_frame_ok && $stable(encoder_ctrl_word_one))
        else $error("bad output frame length not flagged");
endmodule
`default_nettype wire

// ### design/ectf_cfg.svh
// Frame layout constants for the cyclic telegram framer
`ifndef ECTF_CFG_SVH
`define ECTF_CFG_SVH
// Widest input frame in bits (telegram with wide position)
`define ECTF_FRAME_BITS 160
// Input frame lengths in octets per telegram
`define ECTF_LEN_T81    8'h0C
`define ECTF_LEN_T82    8'h0E
`define ECTF_LEN_T83    8'h10
`define ECTF_LEN_T84    8'h14
// Octet index of the last octet of a two-word output frame
`define ECTF_RX_LASTIDX 3'h3
// Octet counter ceiling for over-long output frames
`define ECTF_RX_SAT     3'h7
`endif

// ### design/ectf_pkg.sv
// Types shared by the cyclic telegram framer
package ectf_pkg;
    typedef enum logic [1:0] {
        ECTF_TG81 = 2'h0,
        ECTF_TG82 = 2'h1,
        ECTF_TG83 = 2'h2,
        ECTF_TG84 = 2'h3
    } ectf_tgram_t;
    typedef enum logic [1:0] {
        ECTF_ST_IDLE = 2'b01,
        ECTF_ST_SEND = 2'b10
    } ectf_state_t;
endpackage

// ### design/ectf_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ectf_skid_buf #(
    parameter int WIDTH = 9
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             resetn,
    // Filling side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Draining side
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    logic [WIDTH-1:0] d0_reg, d0_next, d1_reg, d1_next;
    logic             v0_reg, v0_next, v1_reg, v1_next;
    logic             push, pop;

    assign in_ready  = ~v1_reg;
    assign out_valid = v0_reg;
    assign out_data  = d0_reg;
    assign push      = in_valid & ~v1_reg;
    assign pop       = v0_reg & out_ready;

    // Ready drops only when both entries hold, so no word is lost on stall
    always_comb begin
        d0_next = d0_reg;
        d1_next = d1_reg;
        v0_next = v0_reg;
        v1_next = v1_reg;
        if (pop && push) begin
            d0_next = in_data;
        end else if (pop) begin
            d0_next = d1_reg;
            v0_next = v1_reg;
            v1_next = 1'b0;
        end else if (push) begin
            if (!v0_reg) begin
                d0_next = in_data;
                v0_next = 1'b1;
            end else begin
                d1_next = in_data;
                v1_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            d0_reg <= '0;
            d1_reg <= '0;
            v0_reg <= 1'b0;
            v1_reg <= 1'b0;
        end else begin
            d0_reg <= d0_next;
            d1_reg <= d1_next;
            v0_reg <= v0_next;
            v1_reg <= v1_next;
        end
    end

    a_buf_order : assert property (@(posedge clk) disable iff (!resetn)
        v1_reg |-> v0_reg) else $error("second entry full while first empty");
endmodule
`default_nettype wire

// ### verification/ectf_ctrl_model.sv
// Controller-side model for the cyclic telegram framer
`timescale 1ns/1ps
`default_nettype none
module ectf_ctrl_model (
    // Clock
    input  wire logic       clk,
    // Input frames from the device
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_last,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    // Output frames to the device
    output logic [7:0]      rx_data,
    output logic            rx_last,
    output logic            rx_valid
);
    // ****
    // Octet sink
    // ****
    logic [7:0] got[$];
    int         last_at;
    int         stall;
    int         cyc;
    initial begin
        tx_ready = 1'b0;
        rx_data  = 8'h00;
        rx_last  = 1'b0;
        rx_valid = 1'b0;
        stall    = 0;
        cyc      = 0;
        last_at  = -1;
    end
    // Ready low two cycles in three so the buffer fills up
    always @(negedge clk) begin
        cyc      <= cyc + 1;
        tx_ready <= (stall == 0) || (cyc % 3 == 0);
    end
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            if (tx_last) begin
                last_at <= got.size();
            end
            got.push_back(tx_data);
        end
    end
    // ****
    // Output frame source
    // ****
    // Released data is inverted so a stale octet never looks valid
    task automatic send(input logic [31:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_data  = w[8*(n-1-i) +: 8];
            rx_last  = (i == n - 1);
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_last  = 1'b0;
        rx_data  = ~rx_data;
    endtask
endmodule
`default_nettype wire

// ### verification/ectf_framer_test.sv
// Self-checking testbench for the cyclic telegram framer
`timescale 1ns/1ps
`default_nettype none
module ectf_framer_test;
    localparam logic [15:0] SW2 = 16'hA1B2;
    localparam logic [15:0] SW1 = 16'hC3D4;
    localparam logic [31:0] P1  = 32'h11223344;
    localparam logic [31:0] P2  = 32'h55667788;
    localparam logic [63:0] PW  = 64'h99AABBCCDDEEFF01;
    localparam logic [15:0] VS  = 16'hF102;
    localparam logic [31:0] VL  = 32'h8A9BACBD;
    logic                   clk, resetn, cfg_class4, frame_req;
    ectf_pkg::ectf_tgram_t  cfg_telegram;
    logic [15:0]            encoder_status_word_two, encoder_status_word_one;
    logic [31:0]            position_value_first, position_value_second;
    logic [63:0]            position_value_wide;
    logic signed [15:0]     speed_value_short;
    logic signed [31:0]     speed_value_long;
    logic [7:0]             tx_data, rx_data;
    logic                   tx_last, tx_valid, tx_ready;
    logic                   rx_last, rx_valid, rx_frame_ok, rx_frame_err;
    logic [15:0]            encoder_ctrl_word_two, encoder_ctrl_word_one;
    logic                   busy, iso_enable, scale_preset_enable;
    int                     error_cnt;
    int                     checked;

    ectf_framer uut (
        .clk, .resetn, .cfg_class4, .cfg_telegram,
        .encoder_status_word_two, .encoder_status_word_one,
        .position_value_first, .position_value_second,
        .position_value_wide, .speed_value_short, .speed_value_long,
        .frame_req, .tx_data, .tx_last, .tx_valid, .tx_ready,
        .rx_data, .rx_last, .rx_valid,
        .encoder_ctrl_word_two, .encoder_ctrl_word_one,
        .rx_frame_ok, .rx_frame_err, .busy, .iso_enable,
        .scale_preset_enable
    );
    ectf_ctrl_model m (
        .clk, .tx_data, .tx_last, .tx_valid, .tx_ready,
        .rx_data, .rx_last, .rx_valid
    );

    always #25 clk = ~clk;

    // ****
    // Shared tasks
    // ****
    task automatic report_and_stop();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        checked++;
        if (exp !== got) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic set_in(input logic x);
        encoder_status_word_two = SW2 ^ {16{x}};
        encoder_status_word_one = SW1 ^ {16{x}};
        position_value_first    = P1 ^ {32{x}};
        position_value_second   = P2 ^ {32{x}};
        position_value_wide     = PW ^ {64{x}};
        speed_value_short       = VS ^ {16{x}};
        speed_value_long        = VL ^ {32{x}};
    endtask

    // ****
    // Scenarios
    // ****
    // Inputs are scrambled right after the request to prove capture
    task automatic t_frame(input ectf_pkg::ectf_tgram_t tg, input int st);
        logic [159:0] e;
        int           n;
        int           k;
        case (tg)
            ectf_pkg::ECTF_TG81: e = {SW2, SW1, P1, P2, 64'h0};
            ectf_pkg::ECTF_TG82: e = {SW2, SW1, P1, P2, VS, 48'h0};
            ectf_pkg::ECTF_TG83: e = {SW2, SW1, P1, P2, VL, 32'h0};
            default:             e = {SW2, SW1, PW, P2, VL};
        endcase
        n = (tg == ectf_pkg::ECTF_TG84) ? 20 : 12 + 2 * int'(tg);
        k = 0;
        m.got.delete();
        m.last_at = -1;
        m.stall = st;
        cfg_telegram = tg;
        frame_req = 1'b1;
        @(negedge clk);
        frame_req = 1'b0;
        set_in(1'b1);
        check("busy", 1, busy);
        while ((m.last_at < 0 || busy !== 1'b0) && k < 300) begin
            @(negedge clk);
            k++;
        end
        if (k == 300) begin
            error_cnt++;
            report_and_stop();
        end
        set_in(1'b0);
        check("octets", n, m.got.size());
        check("last", n - 1, m.last_at);
        for (int i = 0; i < n; i++) begin
            check("octet", e[159-8*i -: 8], m.got[i]);
        end
    endtask
    task automatic t_class(input logic c);
        cfg_class4 = c;
        repeat (2) @(negedge clk);
        check("iso", c, iso_enable);
        check("scale", c, scale_preset_enable);
    endtask
    // A frame of the wrong length must leave the control words alone
    task automatic t_rx(input logic [31:0] w, input int n);
        logic [31:0] old;
        old = {encoder_ctrl_word_two, encoder_ctrl_word_one};
        m.send(w, n);
        check("ok", n == 4, rx_frame_ok);
        check("err", n != 4, rx_frame_err);
        check("ctrl", (n == 4) ? w : old,
              {encoder_ctrl_word_two, encoder_ctrl_word_one});
    endtask
    // Reset in mid-frame drops the frame, the words and the class
    task automatic t_reset();
        frame_req = 1'b1;
        repeat (3) @(negedge clk);
        frame_req = 1'b0;
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        check("reset busy", 0, busy);
        check("reset valid", 0, tx_valid);
        check("reset ctrl", 0,
              {encoder_ctrl_word_two, encoder_ctrl_word_one});
        check("reset class", 0, iso_enable);
        @(negedge clk);
        check("idle busy", 0, busy);
        check("idle valid", 0, tx_valid);
    endtask

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        cfg_class4 = 1'b0;
        frame_req = 1'b0;
        cfg_telegram = ectf_pkg::ECTF_TG81;
        error_cnt = 0;
        checked = 0;
        set_in(1'b0);
        repeat (8) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        check("reset valid", 0, tx_valid);
        t_class(1'b0);
        t_frame(ectf_pkg::ECTF_TG84, 0);
        t_class(1'b1);
        t_frame(ectf_pkg::ECTF_TG81, 0);
        t_frame(ectf_pkg::ECTF_TG82, 0);
        t_frame(ectf_pkg::ECTF_TG83, 0);
        t_frame(ectf_pkg::ECTF_TG84, 1);
        t_frame(ectf_pkg::ECTF_TG82, 1);
        t_rx(32'h5A6B7C8D, 4);
        t_rx(32'h00123456, 3);
        t_rx(32'hE1F20314, 4);
        t_reset();
        t_class(1'b0);
        t_frame(ectf_pkg::ECTF_TG83, 1);
        report_and_stop();
    end
endmodule
`default_nettype wire
